// [hdl/bru_branch_unit.sv]
// branch resolution unit with its axi4-lite control and status window
`include "bru_defines.svh"
`default_nettype none
// Function
// - immediate less-than branches when source negative
// - register not-equal adds second register
// - immediate not-equal branches when source nonzero
// - decode register not-equal opcode and fields
// - decode immediate not-equal opcode and fields
// - sign-extend sixteen-bit immediate by default
// - immediate prefix supplies full thirty-two bits
// - delay flag lets one slot instruction finish
// - no delay flag discards following instruction
// - register branch costs one, two, three cycles
// - immediate branch one cycle if predicted right
// - mispredict costs three or eight cycles
// - hold interrupts until branch and slot done
// - register jump links branch address when flagged
// - register jump absolute or pc-relative
// - immediate jump absolute or relative, optional link
// - register jump two cycles delayed, three otherwise
// - no linking non-delayed register jump forms
// - user vector branch saves then clears mode bits
// - register less-than adds second register
module bru_branch_unit
	import bru_pkg::*;
#(
	parameter bit memory_management_enable_setting = 1'b1,
	parameter int area_optimization_setting        = 0
) (
	input  wire logic        i_sys_clk,
	input  wire logic        i_arst_n,
	input  wire bru_instr_t  i_instr,
	input  wire logic [31:0] i_first_source_register,
	input  wire logic [31:0] i_second_source_register,
	input  wire logic        i_slot_done,
	input  wire logic        i_irq_req,
	input  wire logic        i_brk_req,
	output var  bru_result_t o_result,
	output logic             o_illegal,
	output logic             o_irq_take,
	output logic             o_brk_take,
	output logic             o_user_mode_bit,
	output logic             o_virtual_mode_bit,
	output logic             o_saved_user_mode_bit,
	output logic             o_saved_virtual_mode_bit,
	input  wire logic [3:0]  i_awaddr,
	input  wire logic        i_awvalid,
	output logic             o_awready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	input  wire logic        i_wvalid,
	output logic             o_wready,
	output logic [1:0]       o_bresp,
	output logic             o_bvalid,
	input  wire logic        i_bready,
	input  wire logic [3:0]  i_araddr,
	input  wire logic        i_arvalid,
	output logic             o_arready,
	output logic [31:0]      o_rdata,
	output logic [1:0]       o_rresp,
	output logic             o_rvalid,
	input  wire logic        i_rready
);
	////////////////////////////////////////////////////////////////////////////////
	// reset release
	logic       rst_meta_n;
	logic       rst_n;
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rst_meta_n <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_n      <= rst_meta_n;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// software registers
	logic [31:0] vector_base_setting;
	logic        mode_write;
	logic        mode_wr_um;
	logic        mode_wr_vm;
	logic [31:0] last_target;
	logic [31:0] last_link;
	logic [15:0] taken_count;

	////////////////////////////////////////////////////////////////////////////////
	// field decode
	logic [3:0]  cond_code;
	logic        f_delay;
	logic        f_abs;
	logic        f_link;
	logic        is_cond_reg;
	logic        is_cond_imm;
	logic        is_unc_reg;
	logic        is_unc_imm;
	logic [31:0] imm32;
	logic        src_neg;
	logic        src_nz;
	// conditional forms carry delay flag and condition in the destination slot
	assign cond_code   = i_instr.dest[3:0];
	assign f_delay     = (i_instr.opcode == `BRU_OP_UNC_REG || i_instr.opcode == `BRU_OP_UNC_IMM)
		? i_instr.src_a_field[4] : i_instr.dest[4];
	assign f_abs       = i_instr.src_a_field[3];
	assign f_link      = i_instr.src_a_field[2];
	assign is_cond_reg = i_instr.valid && i_instr.opcode == `BRU_OP_COND_REG;
	assign is_cond_imm = i_instr.valid && i_instr.opcode == `BRU_OP_COND_IMM;
	assign is_unc_reg  = i_instr.valid && i_instr.opcode == `BRU_OP_UNC_REG;
	assign is_unc_imm  = i_instr.valid && i_instr.opcode == `BRU_OP_UNC_IMM;
	// prefix wins over sign extension
	assign imm32 = i_instr.imm_prefix ? {i_instr.imm_high, i_instr.imm16}
		: {{16{i_instr.imm16[15]}}, i_instr.imm16};
	// whole-word signed compare, not just the sign of a slice
	assign src_neg = $signed(i_first_source_register) < 0;
	assign src_nz  = i_first_source_register != 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////////////
	// resolution: taken, target, link
	logic        is_branch;
	logic        taken;
	logic        cond_ok;
	logic        bad_form;
	logic [31:0] offset;
	logic [31:0] target;
	logic        do_link;
	logic        user_vec;
	always_comb begin
		cond_ok  = 1'b0;
		bad_form = 1'b0;
		offset   = 32'h0000_0000;
		target   = i_instr.pc + `BRU_PC_STEP;
		do_link  = 1'b0;
		if (is_cond_reg || is_cond_imm) begin
			unique case (cond_code)
				`BRU_CC_NE: cond_ok = src_nz;
				`BRU_CC_LT: cond_ok = src_neg;
				default:    bad_form = 1'b1;
			endcase
			offset = is_cond_reg ? i_second_source_register : imm32;
			if (cond_ok) begin
				target = i_instr.pc + offset;
			end
		end else if (is_unc_reg) begin
			// linking without delay, and link-less encodings with L only, do not exist
			bad_form = f_link && !f_delay;
			target   = f_abs ? i_second_source_register
				: i_instr.pc + i_second_source_register;
			do_link  = f_link && !bad_form;
		end else if (is_unc_imm) begin
			bad_form = f_link && !f_delay;
			target   = f_abs ? imm32 : i_instr.pc + imm32;
			do_link  = f_link && !bad_form;
		end
	end
	assign is_branch = is_cond_reg || is_cond_imm || is_unc_reg || is_unc_imm;
	assign taken     = !bad_form && (cond_ok || is_unc_reg || is_unc_imm);
	assign user_vec  = memory_management_enable_setting && is_unc_imm && f_delay && f_abs
		&& f_link && imm32 == vector_base_setting + `BRU_USER_VEC_OFS;

	////////////////////////////////////////////////////////////////////////////////
	// cycle charge for this branch
	logic [3:0] cycles;
	logic       mispredict;
	assign mispredict = is_cond_imm && !bad_form && (i_instr.predicted_taken != taken);
	always_comb begin
		if (!is_branch || bad_form) begin
			cycles = 4'h0;
		end else if (mispredict) begin
			cycles = (area_optimization_setting == 2) ? `BRU_LAT_MISP_DEEP
				: `BRU_LAT_MISP_AREA;
		end else if (!taken || (is_cond_imm && i_instr.predicted_taken)) begin
			cycles = {2'b00, `BRU_LAT_NOT_TAKEN};
		end else if (f_delay) begin
			cycles = {2'b00, `BRU_LAT_DELAY};
		end else begin
			cycles = {2'b00, `BRU_LAT_NO_DELAY};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// registered result toward fetch and write-back
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_result  <= '0;
			o_illegal <= 1'b0;
		end else begin
			o_result.redirect     <= taken;
			o_result.next_pc      <= target;
			o_result.link_we      <= do_link;
			o_result.link_dest    <= i_instr.dest;
			o_result.link_data    <= i_instr.pc;
			o_result.kill_next    <= taken && !f_delay;
			o_result.stall_cycles <= cycles;
			o_illegal             <= is_branch && bad_form;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// delay-slot tracker; interrupts wait for branch and slot
	bru_state_t state;
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= BRU_IDLE;
		end else begin
			unique case (state)
				BRU_IDLE:  if (taken) state <= f_delay ? BRU_SLOT : BRU_FLUSH;
				BRU_SLOT:  if (i_slot_done) state <= BRU_IDLE;
				BRU_FLUSH: state <= BRU_IDLE;
			endcase
		end
	end
	// a branch in the decode slot also blocks, so the request lands after it
	assign o_irq_take = i_irq_req && state == BRU_IDLE && !is_branch;
	assign o_brk_take = i_brk_req && state == BRU_IDLE && !is_branch;

	////////////////////////////////////////////////////////////////////////////////
	// machine status word mode bits
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_user_mode_bit          <= 1'b0;
			o_virtual_mode_bit       <= 1'b0;
			o_saved_user_mode_bit    <= 1'b0;
			o_saved_virtual_mode_bit <= 1'b0;
		end else if (user_vec) begin
			o_saved_user_mode_bit    <= o_user_mode_bit;
			o_saved_virtual_mode_bit <= o_virtual_mode_bit;
			o_user_mode_bit          <= 1'b0;
			o_virtual_mode_bit       <= 1'b0;
		end else if (mode_write) begin
			o_user_mode_bit    <= mode_wr_um;
			o_virtual_mode_bit <= mode_wr_vm;
		end
	end

	// last branch record for software
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			last_target <= 32'h0000_0000;
			last_link   <= 32'h0000_0000;
			taken_count <= 16'h0000;
		end else if (taken) begin
			last_target <= target;
			last_link   <= i_instr.pc;
			taken_count <= taken_count + 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// axi4-lite write channel; address and data held until both present
	logic aw_held;
	logic w_held;
	logic [3:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        wr_go;
	assign o_awready = !aw_held && !o_bvalid;
	assign o_wready  = !w_held && !o_bvalid;
	assign wr_go     = aw_held && w_held && !o_bvalid;
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 4'h0;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
			o_bvalid <= 1'b0;
			o_bresp  <= `BRU_AXI_OKAY;
		end else begin
			if (i_awvalid && o_awready) begin
				aw_held <= 1'b1;
				aw_addr <= i_awaddr;
			end
			if (i_wvalid && o_wready) begin
				w_held <= 1'b1;
				w_data <= i_wdata;
				w_strb <= i_wstrb;
			end
			if (wr_go) begin
				aw_held  <= 1'b0;
				w_held   <= 1'b0;
				o_bvalid <= 1'b1;
				o_bresp  <= (aw_addr == `BRU_REG_CTRL) ? `BRU_AXI_OKAY : `BRU_AXI_SLVERR;
			end else if (o_bvalid && i_bready) begin
				o_bvalid <= 1'b0;
			end
		end
	end
	// control word: [1:0] mode bits when byte 0 enabled; base vector reload on byte 1..3
	assign mode_write = wr_go && aw_addr == `BRU_REG_CTRL && w_strb[0];
	assign mode_wr_um = w_data[0];
	assign mode_wr_vm = w_data[1];
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			vector_base_setting <= `BRU_BASE_VEC_RST;
		end else if (wr_go && aw_addr == `BRU_REG_CTRL) begin
			for (int b = 1; b < 4; b++) begin
				if (w_strb[b]) vector_base_setting[b*8 +: 8] <= w_data[b*8 +: 8];
			end
		end
	end

	// axi4-lite read channel, one cycle answer
	assign o_arready = !o_rvalid;
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_rvalid <= 1'b0;
			o_rdata  <= 32'h0000_0000;
			o_rresp  <= `BRU_AXI_OKAY;
		end else if (i_arvalid && o_arready) begin
			o_rvalid <= 1'b1;
			o_rresp  <= `BRU_AXI_OKAY;
			unique case (i_araddr)
				`BRU_REG_CTRL:   o_rdata <= {vector_base_setting[31:8], 6'h00,
					o_virtual_mode_bit, o_user_mode_bit};
				`BRU_REG_STAT:   o_rdata <= {taken_count, 12'h000, o_saved_virtual_mode_bit,
					o_saved_user_mode_bit, state};
				`BRU_REG_TARGET: o_rdata <= last_target;
				`BRU_REG_LINK:   o_rdata <= last_link;
				default: begin
					o_rdata <= 32'h0000_0000;
					o_rresp <= `BRU_AXI_SLVERR;
				end
			endcase
		end else if (o_rvalid && i_rready) begin
			o_rvalid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// [hdl/bru_defines.svh]
// constants for the branch resolution unit
`ifndef BRU_DEFINES_SVH
`define BRU_DEFINES_SVH
`define BRU_OP_COND_REG    6'h27
`define BRU_OP_COND_IMM    6'h2f
`define BRU_OP_UNC_REG     6'h26
`define BRU_OP_UNC_IMM     6'h2e
`define BRU_CC_NE          4'h1
`define BRU_CC_LT          4'h2
`define BRU_PC_STEP        32'h0000_0004
`define BRU_USER_VEC_OFS   32'h0000_0008
`define BRU_LAT_NOT_TAKEN  2'h1
`define BRU_LAT_DELAY      2'h2
`define BRU_LAT_NO_DELAY   2'h3
`define BRU_LAT_MISP_AREA  4'h3
`define BRU_LAT_MISP_DEEP  4'h8
`define BRU_BASE_VEC_RST   32'h0000_0000
`define BRU_AXI_OKAY       2'h0
`define BRU_AXI_SLVERR     2'h2
`define BRU_REG_CTRL       4'h0
`define BRU_REG_STAT       4'h4
`define BRU_REG_TARGET     4'h8
`define BRU_REG_LINK       4'hc
`endif

// [hdl/bru_pkg.sv]
// types for the branch resolution unit
`default_nettype none
package bru_pkg;
	typedef enum logic [1:0] {BRU_IDLE, BRU_SLOT, BRU_FLUSH} bru_state_t;
	typedef struct packed {
		logic        valid;
		logic [31:0] pc;
		logic [5:0]  opcode;
		logic [4:0]  dest;
		logic [4:0]  src_a_field;
		logic [15:0] imm16;
		logic        imm_prefix;
		logic [15:0] imm_high;
		logic        predicted_taken;
	} bru_instr_t;
	typedef struct packed {
		logic        redirect;
		logic [31:0] next_pc;
		logic        link_we;
		logic [4:0]  link_dest;
		logic [31:0] link_data;
		logic        kill_next;
		logic [3:0]  stall_cycles;
	} bru_result_t;
endpackage
`default_nettype wire

// [tb/bru_branch_unit_asserts.sv]
// concurrent checks on the branch resolution unit ports
`include "bru_defines.svh"
`default_nettype none
module bru_branch_unit_asserts
	import bru_pkg::*;
(
	input wire logic        i_sys_clk,
	input wire logic        i_arst_n,
	input wire bru_instr_t  i_instr,
	input wire logic [31:0] i_first_source_register,
	input wire logic [31:0] i_second_source_register,
	input wire bru_result_t o_result,
	input wire logic        o_illegal,
	input wire logic        o_irq_take,
	input wire logic        o_brk_take,
	input wire logic        o_user_mode_bit,
	input wire logic        o_saved_user_mode_bit
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_arst_n);
	logic        cr, ci, ne, nz, dl;
	logic [31:0] reg_tgt, imm_tgt, seq_pc, at_pc;
	////////////////////////////////////////
	// decode shorthands for the instruction now at the input
	assign cr = i_instr.valid && i_instr.opcode == `BRU_OP_COND_REG;
	assign ci = i_instr.valid && i_instr.opcode == `BRU_OP_COND_IMM;
	assign ne = i_instr.dest[3:0] == `BRU_CC_NE;
	assign nz = |i_first_source_register;
	assign dl = i_instr.dest[4];
	// expected values one cycle behind, like the registered result
	always_ff @(posedge i_sys_clk) begin
		reg_tgt <= i_instr.pc + i_second_source_register;
		imm_tgt <= i_instr.pc + {{16{i_instr.imm16[15]}}, i_instr.imm16};
		seq_pc  <= i_instr.pc + `BRU_PC_STEP;
		at_pc   <= i_instr.pc;
	end
	////////////////////////////////////////
	ne_reg_taken_a: assert property (cr && ne && nz
		|=> o_result.redirect && o_result.next_pc == reg_tgt) else $error("ne target wrong");
	ne_reg_fall_a: assert property (cr && ne && !nz
		|=> !o_result.redirect && o_result.next_pc == seq_pc && o_result.stall_cycles == 4'h1)
		else $error("fall through wrong");
	lt_imm_taken_a: assert property (ci && i_instr.dest[3:0] == `BRU_CC_LT
		&& i_first_source_register[31] && !i_instr.imm_prefix && !i_instr.predicted_taken
		|=> o_result.redirect && o_result.next_pc == imm_tgt) else $error("lt target wrong");
	reg_slot_keep_a: assert property (cr && ne && nz && dl
		|=> !o_result.kill_next && o_result.stall_cycles == 4'h2) else $error("slot lost");
	reg_slot_kill_a: assert property (cr && ne && nz && !dl
		|=> o_result.kill_next && o_result.stall_cycles == 4'h3) else $error("slot kept");
	illegal_quiet_a: assert property (o_illegal |-> !o_result.redirect)
		else $error("illegal form redirected");
	link_addr_a: assert property (o_result.link_we |-> o_result.link_data == at_pc)
		else $error("link value wrong");
	irq_hold_a: assert property (o_result.redirect && !o_result.kill_next
		|-> !o_irq_take && !o_brk_take) else $error("request taken inside slot");
	user_vec_a: assert property (i_instr.valid && i_instr.opcode == `BRU_OP_UNC_IMM
		&& i_instr.src_a_field[4:2] == 3'h7 && i_instr.imm16 == 16'h0008
		&& !i_instr.imm_prefix |=> !o_user_mode_bit && o_saved_user_mode_bit
		== $past(o_user_mode_bit)) else $error("mode bits not saved");
	// main scenarios reached
	cover property (o_result.kill_next);
	cover property (o_illegal);
	cover property (o_result.link_we && o_result.redirect);
endmodule
`default_nettype wire

// [tb/bru_pipe_model.sv]
// pipeline stand-in that retires the delay-slot instruction after a taken branch
`default_nettype none
module bru_pipe_model
	import bru_pkg::*;
(
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst_n,
	input  wire bru_result_t i_result,
	input  wire logic        i_slow,
	output logic             o_slot_done
);
	logic [1:0] cnt;
	// slot retires two or four cycles after the redirect, so both waits get tried
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt         <= 2'h0;
			o_slot_done <= 1'b0;
		end else begin
			o_slot_done <= (cnt == 2'h1);
			if (i_result.redirect && !i_result.kill_next) begin
				cnt <= i_slow ? 2'h3 : 2'h1;
			end else if (cnt != 2'h0) begin
				cnt <= cnt - 2'h1;
			end
		end
	end
endmodule
`default_nettype wire

// [tb/bru_branch_unit_tb.sv]
// self-checking bench for the branch resolution unit
`default_nettype none
module bru_branch_unit_tb
	import bru_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {
		logic [5:0]  op;
		logic [4:0]  dst;
		logic [4:0]  sa;
		logic [31:0] a;
		logic [31:0] b;
		logic [15:0] imm;
		logic        rd;
		logic [31:0] npc;
		logic        kl;
		logic [3:0]  st;
		logic        lk;
	} bru_row_t;
	localparam logic [31:0] PC = 32'h1000;
	logic        i_sys_clk, i_arst_n, i_slot_done, i_irq_req, i_brk_req, slow;
	bru_instr_t  i_instr;
	bru_result_t o_result;
	logic [31:0] i_first_source_register, i_second_source_register;
	logic        o_illegal, o_irq_take, o_brk_take, o_user_mode_bit, o_virtual_mode_bit;
	logic        o_saved_user_mode_bit, o_saved_virtual_mode_bit;
	logic [3:0]  i_awaddr, i_araddr, i_wstrb;
	logic        i_awvalid, o_awready, i_wvalid, o_wready, o_bvalid, i_bready;
	logic        i_arvalid, o_arready, o_rvalid, i_rready;
	logic [31:0] i_wdata, o_rdata, rv;
	logic [1:0]  o_bresp, o_rresp, rsp;
	int          n_errors, checked;
	bru_row_t    rows [10];
	bru_branch_unit dut (.*);
	bru_pipe_model u_pipe (.i_sys_clk(i_sys_clk), .i_rst_n(i_arst_n), .i_result(o_result),
		.i_slow(slow), .o_slot_done(i_slot_done));
	////////////////////////////////////////
	task automatic end_of_test();
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic tmo(input int n);
		if (n >= 64) begin
			n_errors++;
			end_of_test();
		end
	endtask
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	// one instruction for one cycle; result is settled one edge later
	task automatic issue(input bru_row_t r, input logic pre);
		@(posedge i_sys_clk);
		i_instr <= '{1'b1, PC, r.op, r.dst, r.sa, r.imm, pre, 16'h0001, 1'b0};
		i_first_source_register <= r.a;
		i_second_source_register <= r.b;
		@(posedge i_sys_clk);
		i_instr.valid <= 1'b0;
		#1;
	endtask
	// register writes offer address and data together and wait for the response
	// handshakes are judged on values settled one time unit after the edge before the one that takes them
	task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		int   n;
		logic aw_hs, w_hs, b_hs;
		n = 0;
		r = 2'h0;
		@(posedge i_sys_clk);
		{i_awaddr, i_wdata, i_awvalid, i_wvalid, i_bready} <= {a, d, 3'h7};
		do begin
			#1;
			aw_hs = i_awvalid && o_awready;
			w_hs  = i_wvalid && o_wready;
			b_hs  = o_bvalid && i_bready;
			r     = o_bresp;
			@(posedge i_sys_clk);
			if (aw_hs) i_awvalid <= 1'b0;
			if (w_hs) i_wvalid <= 1'b0;
			n++;
		end while (!b_hs && n < 64);
		i_bready <= 1'b0;
		tmo(n);
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		int   n;
		logic ar_hs, r_hs;
		n = 0;
		d = 32'h0000_0000;
		@(posedge i_sys_clk);
		{i_araddr, i_arvalid, i_rready} <= {a, 2'h3};
		do begin
			#1;
			ar_hs = i_arvalid && o_arready;
			r_hs  = o_rvalid && i_rready;
			d     = o_rdata;
			@(posedge i_sys_clk);
			if (ar_hs) i_arvalid <= 1'b0;
			n++;
		end while (!r_hs && n < 64);
		i_rready <= 1'b0;
		tmo(n);
	endtask
	////////////////////////////////////////
	initial begin
		i_sys_clk = 1'b0;
		forever #20 i_sys_clk = ~i_sys_clk;
	end
	// a hang ends in the same closing report
	initial begin
		repeat (20000) @(posedge i_sys_clk);
		tmo(64);
	end
	initial begin
		{i_instr, i_first_source_register, i_second_source_register, i_wdata} = '0;
		{i_irq_req, i_brk_req, slow, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
		{i_awaddr, i_araddr, i_arst_n, n_errors, checked} = '0;
		i_wstrb = 4'hf;
		rows = '{
			'{6'h27,5'h01,5'h03,32'h5,32'h40,16'h0,1'b1,32'h1040,1'b1,4'h3,1'b0},
			'{6'h27,5'h11,5'h03,32'h5,32'h40,16'h0,1'b1,32'h1040,1'b0,4'h2,1'b0},
			'{6'h27,5'h01,5'h03,32'h0,32'h40,16'h0,1'b0,32'h1004,1'b0,4'h1,1'b0},
			'{6'h27,5'h02,5'h03,32'hffff_ffff,32'h40,16'h0,1'b1,32'h1040,1'b1,4'h3,1'b0},
			'{6'h27,5'h02,5'h03,32'h7fff_ffff,32'h40,16'h0,1'b0,32'h1004,1'b0,4'h1,1'b0},
			'{6'h2f,5'h02,5'h03,32'h8000_0000,32'h0,16'hfff0,1'b1,32'h0ff0,1'b1,4'h3,1'b0},
			'{6'h2f,5'h01,5'h03,32'h1,32'h0,16'h0020,1'b1,32'h1020,1'b1,4'h3,1'b0},
			'{6'h2f,5'h01,5'h03,32'h0,32'h0,16'h0020,1'b0,32'h1004,1'b0,4'h1,1'b0},
			'{6'h26,5'h13,5'h14,32'h0,32'h100,16'h0,1'b1,32'h1100,1'b0,4'h2,1'b1},
			'{6'h26,5'h10,5'h18,32'h0,32'h2000,16'h0,1'b1,32'h2000,1'b0,4'h2,1'b0}};
		repeat (3) @(posedge i_sys_clk);
		i_arst_n <= 1'b1;
		repeat (3) @(posedge i_sys_clk);
		rd(4'h0, rv);
		chk("ctrl_reset", rv, 32'h0);
		// table of ordinary branches
		foreach (rows[i]) begin
			issue(rows[i], 1'b0);
			chk("redirect", 32'(o_result.redirect), 32'(rows[i].rd));
			chk("next_pc", o_result.next_pc, rows[i].npc);
			chk("kill", 32'(o_result.kill_next), 32'(rows[i].kl));
			chk("stall", 32'(o_result.stall_cycles), 32'(rows[i].st));
			chk("link_we", 32'(o_result.link_we), 32'(rows[i].lk));
			if (rows[i].lk) chk("link", o_result.link_data, PC);
			repeat (5) @(posedge i_sys_clk);
		end
		// requests held off while a slow delay slot is still running
		{i_irq_req, i_brk_req, slow} <= 3'h7;
		issue(rows[1], 1'b0);
		chk("irq_take", 32'({o_irq_take, o_brk_take}), 32'h0);
		repeat (8) @(posedge i_sys_clk);
		#1;
		chk("irq_take", 32'(o_irq_take), 32'h1);
		{i_irq_req, i_brk_req} <= 2'h0;
		issue(rows[6], 1'b1);
		chk("prefix", o_result.next_pc, 32'h0001_1020);
		issue('{6'h26,5'h00,5'h04,32'h0,32'h40,16'h0,1'b0,32'h0,1'b0,4'h0,1'b0}, 1'b0);
		chk("illegal", 32'({o_illegal, o_result.redirect}), 32'h2);
		issue('{6'h2e,5'h10,5'h18,32'h0,32'h0,16'h0300,1'b0,32'h0,1'b0,4'h0,1'b0}, 1'b0);
		chk("abs_imm", o_result.next_pc, 32'h0300);
		// user vector branch after software sets both mode bits
		wr(4'h0, 32'h3, rsp);
		chk("bresp", 32'(rsp), 32'h0);
		rd(4'h0, rv);
		chk("ctrl", rv, 32'h3);
		wr(4'h4, 32'h3, rsp);
		chk("bresp_ro", 32'(rsp), 32'h2);
		issue('{6'h2e,5'h13,5'h1c,32'h0,32'h0,16'h0008,1'b0,32'h0,1'b0,4'h0,1'b0}, 1'b0);
		chk("vec_pc", o_result.next_pc, 32'h8);
		repeat (2) @(posedge i_sys_clk);
		#1;
		chk("modes", 32'({o_user_mode_bit, o_virtual_mode_bit, o_saved_user_mode_bit,
			o_saved_virtual_mode_bit}), 32'h3);
		rd(4'h4, rv);
		chk("saved", 32'(rv[3:2]), 32'h3);
		end_of_test();
	end
endmodule
bind bru_branch_unit bru_branch_unit_asserts u_chk (.*);
`default_nettype wire
